//--- design/async_rx_pkg.sv
// shared types and constants for the serial receiver
package async_rx_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RX_DATA_BUFFER = 8'h04;
  localparam logic [7:0] OFF_TX_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] OFF_BAUD_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_BAUD_DIVISOR_HIGH = 8'h10;
  localparam logic [7:0] OFF_BAUD_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] OFF_TX_DATA_BUFFER = 8'h18;
  localparam logic [7:0] OFF_RX_IRQ_CONTROL = 8'h1C;
  // rx_status_control fields
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_NINE_EN = 6;
  localparam int BIT_SINGLE_EN = 5;
  localparam int BIT_CONT_EN = 4;
  localparam int BIT_ADDR_DET = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_NINTH = 0;
  // tx_status_control and baud_control fields
  localparam int B_SYNC = 4;
  localparam int BIT_HIGH_BAUD = 2;
  localparam int BIT_SHIFT_EMPTY = 1;
  localparam int BIT_RX_IDLE = 6;
  localparam int BIT_WIDE_DIV = 3;
  // rx_irq_control fields
  localparam int B_RCFLAG = 0;
  localparam int B_RCIE = 1;
  localparam int B_RCIP = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [1:0] SLOW_PRESCALE_LAST = 2'h3;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apbReq_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apbRsp_type;
endpackage

//--- design/async_serial_receiver.sv
// asynchronous serial receiver with 9-bit address detect and apb registers
// Notes on behaviour
// - sample pin at sixteen times baud rate
// - async mode needs sync clear, enable set
// - nine-bit mode keeps ninth bit readable
// - accept characters only while continuous receive set
// - completed character sets flag, raises interrupt
// - status shows ninth bit, framing, overrun
// - eight data bits read from data register
// - clearing continuous receive clears error flags
// - address detect enable turns detection on in nine-bit mode
// - without address detect, every character buffered while the receive flag is clear; one arriving with it set is an overrun
// - receive interrupt priority chosen by software bit
// - unimplemented bits read as zero
// - one start, eight/nine data, one stop
// - data bits arrive least significant first
// - reading data register clears receive flag
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver (
  input wire logic clock,
  input wire logic nrst,
  input wire async_rx_pkg::apbReq_type apbReq,
  output async_rx_pkg::apbRsp_type apbRsp_ff,
  input wire logic serialInputPin,
  output logic rxIrqHigh_ff,
  output logic rxIrqLow_ff
);
  import async_rx_pkg::*;

  typedef enum logic [1:0] {IDLE, START, DATA, STOP} rxState_type;
  rxState_type state_ff;

  logic [7:0] rxCtl_ff;
  logic [7:0] txSc_ff;
  logic [7:0] txData_ff;
  logic wideDiv_ff;
  logic [7:0] divHi_ff;
  logic [7:0] divLo_ff;
  logic rcIe_ff;
  logic rcIp_ff;
  logic rxFlag_ff;
  logic frameErr_ff;
  logic overrunErr_ff;
  logic ninth_ff;
  logic [7:0] rxData_ff;
  logic rdHadFlag_ff;

  // pin synchroniser and agreement filter
  logic pinS1_ff;
  logic pinS2_ff;
  logic pinS3_ff;
  logic rxLvl_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinS1_ff <= 1'b1;
      pinS2_ff <= 1'b1;
      pinS3_ff <= 1'b1;
      rxLvl_ff <= 1'b1;
    end else begin
      pinS1_ff <= serialInputPin;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      if (pinS2_ff == pinS3_ff) begin
        rxLvl_ff <= pinS3_ff;
      end
    end
  end

  logic rxActive;
  assign rxActive = rxCtl_ff[BIT_PORT_EN] & ~txSc_ff[B_SYNC]
                    & rxCtl_ff[BIT_CONT_EN] & ~overrunErr_ff;

  logic [15:0] divVal;
  logic [15:0] reload;
  logic [15:0] divCnt_ff;
  logic [1:0] pre_ff;
  logic slowMode;
  logic fastMode;
  logic baseTick;
  logic tick;
  assign divVal = wideDiv_ff ? {divHi_ff, divLo_ff} : {8'h00, divLo_ff};
  assign slowMode = ~wideDiv_ff & ~txSc_ff[BIT_HIGH_BAUD];
  assign fastMode = wideDiv_ff & txSc_ff[BIT_HIGH_BAUD];
  assign reload = fastMode ? {2'b00, divVal[15:2]} : divVal;
  assign baseTick = (divCnt_ff == 16'h0000);
  assign tick = baseTick & (~slowMode | (pre_ff == SLOW_PRESCALE_LAST));
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= RST_DIV;
      pre_ff <= 2'h0;
    end else if (!rxActive) begin
      divCnt_ff <= RST_DIV;
      pre_ff <= 2'h0;
    end else if (baseTick) begin
      divCnt_ff <= reload;
      pre_ff <= pre_ff + 2'h1;
    end else begin
      divCnt_ff <= divCnt_ff - 16'h0001;
    end
  end

  logic [3:0] os_ff;
  logic [3:0] bitCnt_ff;
  logic [8:0] shift_ff;
  logic [3:0] lastBit;
  logic midTick;
  logic done;
  assign lastBit = rxCtl_ff[BIT_NINE_EN] ? 4'h8 : 4'h7;
  assign midTick = tick & (os_ff == SAMPLE_POINT);
  // no character completes in the cycle reception is switched off
  assign done = (state_ff == STOP) & midTick & rxActive;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= IDLE;
      os_ff <= 4'h0;
      bitCnt_ff <= 4'h0;
    end else if (!rxActive) begin
      state_ff <= IDLE;
      os_ff <= 4'h0;
      bitCnt_ff <= 4'h0;
    end else if (tick) begin
      os_ff <= os_ff + 4'h1;
      case (state_ff)
        IDLE: begin
          os_ff <= 4'h0;
          if (!rxLvl_ff) begin
            state_ff <= START;
          end
        end
        START: begin
          // a glitch shorter than half a bit is not a start
          if (os_ff == SAMPLE_POINT && rxLvl_ff) begin
            state_ff <= IDLE;
          end else if (os_ff == OVERSAMPLE_LAST) begin
            state_ff <= DATA;
            bitCnt_ff <= 4'h0;
          end
        end
        DATA: begin
          if (os_ff == OVERSAMPLE_LAST) begin
            if (bitCnt_ff == lastBit) begin
              state_ff <= STOP;
            end else begin
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end
          end
        end
        STOP: begin
          // back to idle at mid stop so the next start edge is caught
          if (os_ff == SAMPLE_POINT) begin
            state_ff <= IDLE;
          end
        end
        default: begin
          state_ff <= IDLE;
        end
      endcase
    end
  end

  // lsb first shift at bit rate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= 9'h000;
    end else if (midTick && state_ff == DATA) begin
      shift_ff <= {rxLvl_ff, shift_ff[8:1]};
    end
  end

  logic [7:0] rxByte;
  logic discard;
  logic accept;
  logic overrun;
  assign rxByte = rxCtl_ff[BIT_NINE_EN] ? shift_ff[7:0] : shift_ff[8:1];
  assign discard = done & rxCtl_ff[BIT_ADDR_DET] & rxCtl_ff[BIT_NINE_EN]
                   & ~shift_ff[8];
  assign accept = done & ~discard & ~rxFlag_ff;
  assign overrun = done & ~discard & rxFlag_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxData_ff <= RST_BYTE;
      ninth_ff <= 1'b0;
    end else if (accept) begin
      rxData_ff <= rxByte;
      ninth_ff <= rxCtl_ff[BIT_NINE_EN] & shift_ff[8];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frameErr_ff <= 1'b0;
      overrunErr_ff <= 1'b0;
    end else if (!rxCtl_ff[BIT_CONT_EN]) begin
      frameErr_ff <= 1'b0;
      overrunErr_ff <= 1'b0;
    end else begin
      if (accept) begin
        frameErr_ff <= ~rxLvl_ff;
      end
      // overrun halts reception until receive enable toggles
      if (overrun) begin
        overrunErr_ff <= 1'b1;
      end
    end
  end

  // apb slave, one-cycle access phase
  logic setup;
  logic access;
  logic wrEn;
  logic rdData;
  logic mapped;
  logic [7:0] rdByte;
  assign setup = apbReq.psel & ~apbReq.penable;
  assign access = apbReq.psel & apbReq.penable & apbRsp_ff.pready;
  assign wrEn = access & apbReq.pwrite & ~apbRsp_ff.pslverr;
  assign rdData = access & ~apbReq.pwrite
                  & (apbReq.paddr == OFF_RX_DATA_BUFFER);

  always_comb begin
    mapped = 1'b1;
    rdByte = 8'h00;
    case (apbReq.paddr)
      OFF_RX_STATUS_CONTROL:
        rdByte = {rxCtl_ff[7:3], frameErr_ff, overrunErr_ff, ninth_ff};
      OFF_RX_DATA_BUFFER: rdByte = rxData_ff;
      OFF_TX_STATUS_CONTROL: rdByte = txSc_ff;
      OFF_BAUD_CONTROL:
        rdByte = {1'b0, state_ff == IDLE, 2'b00, wideDiv_ff, 3'b000};
      OFF_BAUD_DIVISOR_HIGH: rdByte = divHi_ff;
      OFF_BAUD_DIVISOR_LOW: rdByte = divLo_ff;
      OFF_TX_DATA_BUFFER: rdByte = txData_ff;
      OFF_RX_IRQ_CONTROL: rdByte = {5'h00, rcIp_ff, rcIe_ff, rxFlag_ff};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      apbRsp_ff <= '0;
      rdHadFlag_ff <= 1'b0;
    end else begin
      apbRsp_ff.pready <= setup;
      if (setup) begin
        apbRsp_ff.pslverr <= ~mapped;
        apbRsp_ff.prdata <= {24'h000000, rdByte};
        rdHadFlag_ff <= rxFlag_ff;
      end
    end
  end

  // transmitter absent: shift-register-empty reads set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxCtl_ff <= RST_BYTE;
      txSc_ff <= RST_TX_STATUS;
      txData_ff <= RST_BYTE;
      wideDiv_ff <= 1'b0;
      divHi_ff <= RST_BYTE;
      divLo_ff <= RST_BYTE;
      rcIe_ff <= 1'b0;
      rcIp_ff <= 1'b0;
    end else if (wrEn) begin
      case (apbReq.paddr)
        OFF_RX_STATUS_CONTROL: rxCtl_ff <= {apbReq.pwdata[7:3], 3'b000};
        OFF_TX_STATUS_CONTROL:
          txSc_ff <= apbReq.pwdata[7:0] | RST_TX_STATUS;
        OFF_BAUD_CONTROL: wideDiv_ff <= apbReq.pwdata[BIT_WIDE_DIV];
        OFF_BAUD_DIVISOR_HIGH: divHi_ff <= apbReq.pwdata[7:0];
        OFF_BAUD_DIVISOR_LOW: divLo_ff <= apbReq.pwdata[7:0];
        OFF_TX_DATA_BUFFER: txData_ff <= apbReq.pwdata[7:0];
        OFF_RX_IRQ_CONTROL: begin
          rcIe_ff <= apbReq.pwdata[B_RCIE];
          rcIp_ff <= apbReq.pwdata[B_RCIP];
        end
        default: begin
        end
      endcase
    end
  end

  // data read clears flag, set wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxFlag_ff <= 1'b0;
    end else if (accept) begin
      rxFlag_ff <= 1'b1;
    end else if (rdData && rdHadFlag_ff) begin
      rxFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxIrqHigh_ff <= 1'b0;
      rxIrqLow_ff <= 1'b0;
    end else begin
      rxIrqHigh_ff <= rxFlag_ff & rcIe_ff & rcIp_ff;
      rxIrqLow_ff <= rxFlag_ff & rcIe_ff & ~rcIp_ff;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_idleWhenOff;
    !rxActive |=> state_ff == IDLE;
  endproperty
  a_idleWhenOff: assert property (p_idleWhenOff)
    else $error("receiver not idle while disabled");

  property p_flagOnAccept;
    accept |=> rxFlag_ff ##1 rxFlag_ff;
  endproperty
  a_flagOnAccept: assert property (p_flagOnAccept)
    else $error("receive flag not set after character");

  property p_readClears;
    rdData && rdHadFlag_ff && !accept |=> !rxFlag_ff;
  endproperty
  a_readClears: assert property (p_readClears)
    else $error("data read did not clear receive flag");

  property p_errClear;
    !rxCtl_ff[BIT_CONT_EN] |=> !frameErr_ff && !overrunErr_ff;
  endproperty
  a_errClear: assert property (p_errClear)
    else $error("errors remain with receive disabled");

  property p_discardKeeps;
    discard |=> $stable(rxData_ff) && !$rose(rxFlag_ff);
  endproperty
  a_discardKeeps: assert property (p_discardKeeps)
    else $error("address filter let a data character in");

  property p_ninth;
    accept && rxCtl_ff[BIT_NINE_EN] |=> ninth_ff == $past(shift_ff[8]);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit not captured");

  property p_dataLoad;
    accept |=> rxData_ff == $past(rxByte);
  endproperty
  a_dataLoad: assert property (p_dataLoad)
    else $error("receive data register wrong");

  property p_framing;
    accept && !rxLvl_ff |=> frameErr_ff;
  endproperty
  a_framing: assert property (p_framing)
    else $error("framing error missed");

  property p_unmappedZero;
    setup && !mapped |=> apbRsp_ff.prdata == 32'h00000000
      && apbRsp_ff.pslverr && apbRsp_ff.pready;
  endproperty
  a_unmappedZero: assert property (p_unmappedZero)
    else $error("unmapped read not zero");

  property p_lsbFirst;
    midTick && state_ff == DATA |=> shift_ff[8] == $past(rxLvl_ff);
  endproperty
  a_lsbFirst: assert property (p_lsbFirst)
    else $error("bit not shifted in at top");

  property p_prio;
    rxFlag_ff && rcIe_ff |=> rxIrqHigh_ff == $past(rcIp_ff)
      && rxIrqLow_ff == !$past(rcIp_ff);
  endproperty
  a_prio: assert property (p_prio)
    else $error("interrupt on wrong priority line");

  property p_startFrame;
    state_ff == IDLE && rxActive && tick && !rxLvl_ff |=> state_ff == START;
  endproperty
  a_startFrame: assert property (p_startFrame)
    else $error("start edge not taken");

  c_accept: cover property (accept);
  c_discard: cover property (discard);
  c_overrun: cover property (overrun);
  c_framing: cover property (accept && !rxLvl_ff);
endmodule
`default_nettype wire

//--- testbench/remote_serial_tx.sv
// behavioural model of the remote transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module remote_serial_tx #(
  parameter int BIT_CLOCKS = 16
) (
  input wire logic clock,
  output var logic serialOut
);
  // line idles high between frames, like a pulled-up link
  initial serialOut = 1'b1;

  task automatic sendChar(input logic [8:0] value, input int nData,
                          input logic stopLevel, input int gapBits);
    int i;
    int k;
    repeat (gapBits * BIT_CLOCKS) @(posedge clock);
    for (i = 0; i < nData + 2; i++) begin
      for (k = 0; k < BIT_CLOCKS; k++) begin
        @(posedge clock);
        if (i == 0) begin
          serialOut <= 1'b0;
        end else if (i == nData + 1) begin
          // a low stop rises after three quarters of the bit, so the
          // receiver sees a framing error but no false start after it
          serialOut <= (k < BIT_CLOCKS * 3 / 4) ? stopLevel : 1'b1;
        end else begin
          serialOut <= value[i-1];
        end
      end
    end
    @(posedge clock);
    serialOut <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- testbench/async_serial_receiver_tb.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_tb;
  import async_rx_pkg::*;
  logic clock;
  logic nrst;
  apbReq_type apbReq;
  apbRsp_type apbRsp;
  logic serialLine;
  logic irqHigh;
  logic irqLow;
  int n_fail;
  int num_checks;
  logic [31:0] rdData;
  logic rdErr;
  logic [31:0] expRst;

  async_serial_receiver u_dut (
    .clock(clock),
    .nrst(nrst),
    .apbReq(apbReq),
    .apbRsp_ff(apbRsp),
    .serialInputPin(serialLine),
    .rxIrqHigh_ff(irqHigh),
    .rxIrqLow_ff(irqLow)
  );
  remote_serial_tx u_remote (.clock(clock), .serialOut(serialLine));

  always #50 clock = ~clock;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                pwdata: wd};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rdData = apbRsp.prdata;
    rdErr = apbRsp.pslverr;
    apbReq <= '0;
    if (apbRsp.pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic rdCheck(input logic [7:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0000_0000);
    check(rdData, exp);
  endtask

  task automatic waitIrq();
    int n;
    n = 0;
    while ((irqHigh | irqLow) !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) begin
      n_fail++;
      stop_test();
    end
  endtask

  // guards against a hang anywhere in the sequence
  initial begin
    #(100 * 50000);
    n_fail++;
    stop_test();
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    apbReq = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    // receiver idle bit reads set while reception is off
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0000_0000);
      expRst = (i == 2) ? 32'h0000_0002 : 32'h0000_0000;
      if (i == 3) begin
        expRst = 32'h0000_0040;
      end
      check(rdData, expRst);
    end
    xfer(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0, rdErr}, 32'h0000_0001);
    check(rdData, 32'h0000_0000);
    xfer(1'b1, OFF_TX_DATA_BUFFER, 32'hFFFF_FF5A);
    rdCheck(OFF_TX_DATA_BUFFER, 32'h0000_005A);
    xfer(1'b1, OFF_BAUD_DIVISOR_HIGH, 32'h0000_0000);
    xfer(1'b1, OFF_BAUD_DIVISOR_LOW, 32'h0000_0000);
    xfer(1'b1, OFF_TX_STATUS_CONTROL, 32'h0000_0004);
    rdCheck(OFF_TX_STATUS_CONTROL, 32'h0000_0006);
    xfer(1'b1, OFF_RX_IRQ_CONTROL, 32'h0000_0002);
    xfer(1'b1, OFF_RX_STATUS_CONTROL, 32'h0000_0090);
    u_remote.sendChar(9'h0A5, 8, 1'b1, 0);
    waitIrq();
    check({30'h0, irqHigh, irqLow}, 32'h0000_0001);
    rdCheck(OFF_RX_IRQ_CONTROL, 32'h0000_0003);
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_0090);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_00A5);
    rdCheck(OFF_RX_IRQ_CONTROL, 32'h0000_0002);
    check({30'h0, irqHigh, irqLow}, 32'h0000_0000);
    xfer(1'b1, OFF_RX_IRQ_CONTROL, 32'h0000_0006);
    u_remote.sendChar(9'h03C, 8, 1'b1, 2);
    waitIrq();
    check({30'h0, irqHigh, irqLow}, 32'h0000_0002);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_003C);
    u_remote.sendChar(9'h055, 8, 1'b0, 1);
    waitIrq();
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_0094);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_0055);
    // two characters back to back without reading the first
    u_remote.sendChar(9'h011, 8, 1'b1, 1);
    u_remote.sendChar(9'h022, 8, 1'b1, 0);
    waitIrq();
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_0092);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_0011);
    xfer(1'b1, OFF_RX_STATUS_CONTROL, 32'h0000_0080);
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_0080);
    u_remote.sendChar(9'h077, 8, 1'b1, 1);
    repeat (20) @(posedge clock);
    rdCheck(OFF_RX_IRQ_CONTROL, 32'h0000_0006);
    xfer(1'b1, OFF_RX_STATUS_CONTROL, 32'h0000_0090);
    xfer(1'b1, OFF_TX_STATUS_CONTROL, 32'h0000_0014);
    u_remote.sendChar(9'h077, 8, 1'b1, 1);
    repeat (20) @(posedge clock);
    rdCheck(OFF_RX_IRQ_CONTROL, 32'h0000_0006);
    xfer(1'b1, OFF_TX_STATUS_CONTROL, 32'h0000_0004);
    xfer(1'b1, OFF_RX_STATUS_CONTROL, 32'h0000_00D8);
    u_remote.sendChar(9'h012, 9, 1'b1, 1);
    repeat (20) @(posedge clock);
    rdCheck(OFF_RX_IRQ_CONTROL, 32'h0000_0006);
    u_remote.sendChar(9'h134, 9, 1'b1, 0);
    waitIrq();
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_00D9);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_0034);
    xfer(1'b1, OFF_RX_STATUS_CONTROL, 32'h0000_00D0);
    u_remote.sendChar(9'h056, 9, 1'b1, 1);
    waitIrq();
    rdCheck(OFF_RX_STATUS_CONTROL, 32'h0000_00D0);
    rdCheck(OFF_RX_DATA_BUFFER, 32'h0000_0056);
    stop_test();
  end
endmodule
`default_nettype wire
